// File: include/tesc_pkg.sv
// Package with constants, types and register map of the trigger/strobe control block
package tesc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DEGLITCH_NS = 400;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Least time rounds up
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LINE_PERIOD_NS = 16_000;
  localparam int unsigned LINE_CYC = LINE_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register map (word offsets on the plain port)
  // ==========================================================================
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_PRESET = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_WIDTH = 4'h3;

  // Configuration register fields
  localparam int unsigned CFG_WIDTH_EN_BIT = 0;
  localparam int unsigned CFG_LINK_INV_BIT = 1;
  localparam int unsigned CFG_SEL_LO_BIT = 5;
  localparam int unsigned CFG_SEL_HI_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Shutter selector positions
  localparam logic [3:0] SHUTTER_NONE = 4'h0;
  localparam logic [3:0] SHUTTER_WIDTH_POS = 4'h9;

  // Default preset lengths in line periods, positions 1..9
  localparam logic [7:0] PRESET_RESET = 8'h04;

  // Output select codes (hi, lo)
  localparam logic [1:0] SEL_HIGH = 2'h0;
  localparam logic [1:0] SEL_FLASH = 2'h1;
  localparam logic [1:0] SEL_BUSY = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    TESC_IDLE = 4'b0001,
    TESC_ARMED = 4'b0010,
    TESC_MEASURE = 4'b0100,
    TESC_EXPOSE = 4'b1000
  } tesc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tesc_req_t;

endpackage

// File: logic/tesc_filter.sv
// Two-flop synchroniser with a stable-count glitch filter for one pin
`timescale 1ns/1ps
module tesc_filter
  import tesc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  localparam int CW = $clog2(STABLE_CYC + 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [CW-1:0] cnt;
  } tesc_flt_t;

  tesc_flt_t q, d;

  // ==========================================================================
  // Filter: level changes only after the synced pin stays put long enough
  // ==========================================================================
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    if (q.s2 == q.lvl) begin
      d.cnt = '0;
    end else if (q.cnt == CW'(STABLE_CYC - 1)) begin
      d.lvl = q.s2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  // Idle level is high: both triggers rest high when unused
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule

// File: logic/tesc_top.sv
// Exposure trigger and flash/busy output control, top level
// Behaviour
// - Selector position zero gives continuous output with no shutter at all.
// - Preset exposure starts on the rising, trailing edge of the trigger.
// - Preset exposure length comes from the preset, not trigger width.
// - Width mode samples trigger low time on line-sync leading edge.
// - Low time of n to n+1 lines gives n lines exposure, n>=1.
// - Width mode only with width enable set and selector at nine.
// - Unaligned triggers may give up to one line length error.
// - Link trigger is active low, with a configurable inversion.
// - Power-connector trigger is always active low, never inverted.
// - Output pin shows constant high, flash timing, or busy.
// - Output selection resets to constant high.
// - Select bits come from configuration bits five and six.
// - Flash timing is produced in continuous and triggered modes alike.
// - In continuous mode flash timing is high only during exposure.
// - Either trigger asserted makes the internal trigger active.
// - With width enable, selector positions one to eight are presets.
`timescale 1ns/1ps
module tesc_top
  import tesc_pkg::*;
#(
  parameter int unsigned LINES_W = 8,
  parameter int unsigned LINE_CYCLES = LINE_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Camera controls and pins
  input wire logic [3:0] shutter_sel_i,
  input wire logic power_conn_trigger_i,
  input wire logic link_trigger_i,
  // Timing outputs
  output logic line_sync_pulse_o,
  output logic exposure_o,
  output logic flash_pin_o
);

  localparam int LCW = $clog2(LINE_CYCLES + 1);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] preset;
    logic [7:0] rdata;
    tesc_state_t st;
    logic trig_d;
    logic [LCW-1:0] line_cnt;
    logic line_sync;
    logic [LINES_W-1:0] width;
    logic [LINES_W-1:0] remain;
    logic expose;
    logic pin;
  } tesc_top_t;

  tesc_top_t q, d;
  tesc_req_t req;
  logic pwr_lvl, link_raw, link_lvl;
  logic trig_act, trig_rise, line_end, cont_mode, width_mode, busy;
  logic [1:0] sel;

  // ==========================================================================
  // Trigger conditioning
  // ==========================================================================
  // Bundle the port so the sequencer sees one request word
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // Each pin filtered on its own so a glitch cannot leak through the OR
  tesc_filter u_pwr_flt (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(power_conn_trigger_i),
    .level_o(pwr_lvl)
  );
  tesc_filter u_link_flt (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(link_trigger_i),
    .level_o(link_raw)
  );

  // Inversion after filtering; the power input is never inverted
  // Flipping the invert bit while the link rests moves the trigger by itself,
  // so software should change polarity only while no exposure is wanted
  assign link_lvl = link_raw ^ q.cfg[CFG_LINK_INV_BIT];
  // Active-low OR: internal trigger active when either is low
  assign trig_act = ~(pwr_lvl & link_lvl);
  assign trig_rise = q.trig_d & ~trig_act;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  // The selector is a level on this clock, so it needs no synchroniser
  assign cont_mode = (shutter_sel_i == SHUTTER_NONE);
  assign width_mode = q.cfg[CFG_WIDTH_EN_BIT] && (shutter_sel_i == SHUTTER_WIDTH_POS);
  assign line_end = (q.line_cnt == LCW'(LINE_CYCLES - 1));
  assign sel = {q.cfg[CFG_SEL_HI_BIT], q.cfg[CFG_SEL_LO_BIT]};
  assign busy = (q.st != TESC_IDLE);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;
    d.trig_d = trig_act;
    // Free-running line timing; the sync pulse is one cycle at line end
    d.line_cnt = line_end ? '0 : q.line_cnt + LCW'(1);
    d.line_sync = line_end;
    // Register writes; unmapped addresses fall through and change nothing
    if (req.wr && req.addr == ADDR_CFG) begin
      d.cfg = req.wdata;
    end
    if (req.wr && req.addr == ADDR_PRESET) begin
      d.preset = req.wdata;
    end
    // Read data stands one cycle after the strobe only
    d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_CFG: d.rdata = q.cfg;
        ADDR_PRESET: d.rdata = q.preset;
        ADDR_STATUS: d.rdata = {3'h0, q.st == TESC_EXPOSE, busy, cont_mode, width_mode,
                                trig_act};
        ADDR_WIDTH: d.rdata = 8'(q.width);
        default: d.rdata = 8'h00;
      endcase
    end
    // Exposure sequencer
    unique case (q.st)
      TESC_IDLE: begin
        d.expose = 1'b0;
        // Selector zero wins over any trigger: no shutter at all
        if (cont_mode) begin
          d.expose = 1'b1;
        end else if (trig_act) begin
          d.width = '0;
          d.st = width_mode ? TESC_MEASURE : TESC_ARMED;
        end
      end
      TESC_ARMED: begin
        if (cont_mode) begin
          d.st = TESC_IDLE;
        end else if (trig_rise) begin
          // Length fixed by the preset; low time not looked at
          d.remain = LINES_W'(q.preset);
          d.st = TESC_EXPOSE;
          d.expose = 1'b1;
        end
      end
      TESC_MEASURE: begin
        // Count whole lines seen low at each line-sync end; phase gives 1 line slack
        // Count stops at all ones so a stuck trigger cannot wrap to a short exposure
        if (line_end && trig_act && q.width != '1) begin
          d.width = q.width + LINES_W'(1);
        end
        if (cont_mode) begin
          d.st = TESC_IDLE;
        end else if (trig_rise) begin
          if (q.width == '0) begin
            d.st = TESC_IDLE; // Shorter than one line: no exposure
          end else begin
            d.remain = q.width;
            d.st = TESC_EXPOSE;
            d.expose = 1'b1;
          end
        end
      end
      TESC_EXPOSE: begin
        // Preset zero still gives one line, as the end test is less-or-equal
        if (line_end) begin
          if (q.remain <= LINES_W'(1)) begin
            d.st = TESC_IDLE;
            d.expose = 1'b0;
          end else begin
            d.remain = q.remain - LINES_W'(1);
          end
        end
      end
      default: d.st = TESC_IDLE;
    endcase
    // Output pin multiplexer; flash follows exposure in every mode
    // Busy covers armed, measuring and exposing, so a strobe unit sees a taken trigger
    // Code 11 is undefined for the pin and falls back to the safe high level
    unique case (sel)
      SEL_FLASH: d.pin = d.expose;
      SEL_BUSY: d.pin = (d.st != TESC_IDLE);
      default: d.pin = 1'b1;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset drives the pin high at once, so no flash fires while the camera starts
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg <= CFG_RESET;
      q.preset <= PRESET_RESET;
      q.st <= TESC_IDLE;
      q.trig_d <= 1'b0;
      q.pin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign line_sync_pulse_o = q.line_sync;
  assign exposure_o = q.expose;
  assign flash_pin_o = q.pin;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  cont_no_shutter_a: assert property (
    cont_mode && q.st == TESC_IDLE |=> exposure_o)
    else $error("continuous mode lost exposure");
  preset_start_a: assert property (
    q.st == TESC_ARMED && trig_rise && !cont_mode |=> q.st == TESC_EXPOSE && exposure_o)
    else $error("preset exposure did not start on trailing edge");
  preset_len_a: assert property (
    q.st == TESC_ARMED && trig_rise && !cont_mode |=> q.remain == LINES_W'($past(q.preset)))
    else $error("preset length not taken from preset");
  width_count_a: assert property (
    q.st == TESC_MEASURE && line_end && trig_act && !trig_rise && q.width != '1
    |=> q.width == $past(q.width) + LINES_W'(1))
    else $error("width not counted on line sync");
  width_len_a: assert property (
    q.st == TESC_MEASURE && trig_rise && !cont_mode && q.width != '0
    |=> q.remain == $past(q.width) && exposure_o)
    else $error("width exposure length wrong");
  width_gate_a: assert property (
    q.st == TESC_IDLE && trig_act && !cont_mode && !width_mode |=> q.st == TESC_ARMED)
    else $error("width mode entered without enable and position nine");
  link_invert_a: assert property (
    q.cfg[CFG_LINK_INV_BIT] && pwr_lvl && link_raw |-> trig_act)
    else $error("link inversion ignored");
  power_pol_a: assert property (
    !pwr_lvl |-> trig_act)
    else $error("power trigger not active low");
  pin_high_a: assert property (
    sel != SEL_FLASH && sel != SEL_BUSY |=> flash_pin_o)
    else $error("pin not high for off selection");
  pin_flash_a: assert property (
    sel == SEL_FLASH && $stable(sel) |-> flash_pin_o == exposure_o)
    else $error("flash pin does not follow exposure");
  pin_busy_a: assert property (
    sel == SEL_BUSY && $stable(sel) |-> flash_pin_o == busy)
    else $error("busy pin does not follow the sequencer");
  link_normal_a: assert property (
    !q.cfg[CFG_LINK_INV_BIT] && !link_raw |-> trig_act)
    else $error("link trigger not active low by default");
  trig_merge_a: assert property (
    pwr_lvl && link_lvl |-> !trig_act)
    else $error("internal trigger active with both inputs idle");

  // ==========================================================================
  // Sequencer checks
  // ==========================================================================
  // An edge that is missed or taken twice shifts every later exposure
  no_early_a: assert property (
    q.st == TESC_ARMED && !trig_rise && !cont_mode |=> q.st == TESC_ARMED && !exposure_o)
    else $error("exposure began before the trailing edge");
  expose_hold_a: assert property (
    q.st == TESC_EXPOSE && !line_end |=> q.st == TESC_EXPOSE && exposure_o)
    else $error("exposure ended between line syncs");
  expose_end_a: assert property (
    q.st == TESC_EXPOSE && line_end && q.remain <= LINES_W'(1)
    |=> q.st == TESC_IDLE && !exposure_o)
    else $error("exposure overran its line count");
  width_short_a: assert property (
    q.st == TESC_MEASURE && trig_rise && !cont_mode && q.width == '0
    |=> q.st == TESC_IDLE && !exposure_o)
    else $error("pulse under one line started an exposure");
  width_sat_a: assert property (
    q.st == TESC_MEASURE && q.width == '1 |=> q.width == '1)
    else $error("width count wrapped");
  cont_abort_a: assert property (
    cont_mode && (q.st == TESC_ARMED || q.st == TESC_MEASURE) |=> q.st == TESC_IDLE)
    else $error("pending trigger kept in continuous mode");
  preset_pos_a: assert property (
    q.st == TESC_IDLE && trig_act && !cont_mode && shutter_sel_i != SHUTTER_WIDTH_POS
    |=> q.st == TESC_ARMED)
    else $error("positions one to eight left preset mode");
  line_sync_a: assert property (
    line_sync_pulse_o |=> !line_sync_pulse_o)
    else $error("line sync pulse longer than one cycle");

  // Main scenarios the bench is expected to reach
  preset_cv: cover property (q.st == TESC_ARMED ##[1:1000] q.st == TESC_EXPOSE);
  width_cv: cover property (q.st == TESC_MEASURE ##[1:1000] q.st == TESC_EXPOSE);
  busy_cv: cover property (sel == SEL_BUSY && flash_pin_o);
  cont_cv: cover property (cont_mode && exposure_o);
  inv_link_cv: cover property (q.cfg[CFG_LINK_INV_BIT] && trig_rise);

endmodule

// File: verification/tesc_top_tb_top.sv
// Self-checking bench for the trigger, exposure and flash output block
`timescale 1ns/1ps
module tesc_top_tb_top;
  import tesc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int LC = 20; // Short lines keep the run brief
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] shutter_sel_i = 4'h1;
  logic [7:0] reg_rdata_o;
  logic [7:0] d;
  logic power_conn_trigger_i, link_trigger_i, line_sync_pulse_o, exposure_o, flash_pin_o;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int tno = 0;
  int n_sync = 0;

  tesc_top #(.LINE_CYCLES(LC)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .shutter_sel_i(shutter_sel_i),
    .power_conn_trigger_i(power_conn_trigger_i), .link_trigger_i(link_trigger_i),
    .line_sync_pulse_o(line_sync_pulse_o), .exposure_o(exposure_o),
    .flash_pin_o(flash_pin_o)
  );
  tesc_trig_model trig (
    .ref_clk_i(ref_clk_i), .power_conn_trigger_o(power_conn_trigger_i),
    .link_trigger_o(link_trigger_i)
  );

  // Clock and hang guard; the ceiling is several times the expected run
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  // Times one exposure; the pin is sampled one line into it
  task automatic meas(output int dly, output int len, output logic mid);
    dly = 0;
    len = 0;
    mid = 1'bx;
    while (exposure_o !== 1'b1 && dly < 40) begin
      @(posedge ref_clk_i);
      #1 dly++;
    end
    while (exposure_o === 1'b1 && len < 1000) begin
      if (len == LC)
        mid = flash_pin_o;
      @(posedge ref_clk_i);
      #1 len++;
    end
  endtask

  // One triggered exposure with a given setup and an allowed length band
  task automatic run(input logic [7:0] cfg, input logic [3:0] sel, input bit link,
                     input int low, input int lo, input int hi);
    int dly;
    int len;
    logic mid;
    logic idle_pin;
    idle_pin = (cfg[6:5] == 2'b01 || cfg[6:5] == 2'b10) ? 1'b0 : 1'b1;
    wr_reg(ADDR_CFG, cfg);
    shutter_sel_i <= sel;
    repeat (LC) @(posedge ref_clk_i);
    #1 check(8'(flash_pin_o), 8'(idle_pin));
    trig.pulse(link, low);
    #1 check(8'(exposure_o), 8'h00);
    meas(dly, len, mid);
    check(8'(dly >= 1 && dly <= 12), 8'h01);
    check(8'(len >= lo && len <= hi), 8'h01);
    check(8'(mid), 8'h01);
    repeat (4) @(posedge ref_clk_i);
    #1 check(8'(flash_pin_o), 8'(idle_pin));
    tno++;
    $display("test %0d done", tno);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_reg(ADDR_CFG, d);
    check(d, CFG_RESET);
    check(8'(flash_pin_o), 8'h01);
    rd_reg(ADDR_PRESET, d);
    check(d, PRESET_RESET);
    rd_reg(4'hf, d);
    check(d, 8'h00);
    // Line sync is one cycle high in every line of LC cycles
    repeat (4 * LC) begin
      @(posedge ref_clk_i);
      #1 n_sync += int'(line_sync_pulse_o);
    end
    check(8'(n_sync), 8'h04);
    // Preset of three lines whatever the trigger width
    wr_reg(ADDR_PRESET, 8'h03);
    run(8'h20, 4'h1, 1'b0, 2 * LC, 2 * LC + 1, 3 * LC + 1);
    run(8'h40, 4'h1, 1'b1, 5 * LC, 2 * LC + 1, 3 * LC + 1);
    run(8'h61, 4'h4, 1'b0, 6 * LC, 2 * LC + 1, 3 * LC + 1);
    run(8'h00, 4'h9, 1'b0, 40 * LC, 2 * LC + 1, 3 * LC + 1);
    // Width mode: a long preset shows that the measured width wins
    wr_reg(ADDR_PRESET, 8'h07);
    run(8'h21, 4'h9, 1'b0, 2 * LC + LC / 2, LC + 1, 3 * LC + 1);
    rd_reg(ADDR_WIDTH, d);
    check(8'(d == 8'h02 || d == 8'h03), 8'h01);
    // Inverted link idles low; the power pin keeps its low polarity
    @(posedge ref_clk_i);
    trig.link_act <= 1'b1;
    wr_reg(ADDR_CFG, 8'h02);
    // Flipping polarity fakes one trigger edge; let that exposure run out first
    repeat (10 * LC) @(posedge ref_clk_i);
    run(8'h02, 4'h1, 1'b1, 2 * LC, 6 * LC + 1, 7 * LC + 1);
    rd_reg(ADDR_STATUS, d);
    check(d & 8'h01, 8'h00);
    run(8'h02, 4'h1, 1'b0, 3 * LC, 6 * LC + 1, 7 * LC + 1);
    // A two-cycle glitch must not start anything
    trig.pulse(1'b0, 2);
    repeat (12) @(posedge ref_clk_i);
    #1 check(8'(exposure_o), 8'h00);
    // Selector zero: continuous exposure, trigger has no say
    wr_reg(ADDR_CFG, 8'h20);
    shutter_sel_i <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
    #1 check(8'(exposure_o), 8'h01);
    check(8'(flash_pin_o), 8'h01);
    trig.pulse(1'b0, LC);
    repeat (8 * LC) @(posedge ref_clk_i);
    #1 check(8'(exposure_o), 8'h01);
    tno++;
    $display("test %0d done", tno);
    print_verdict();
  end
endmodule

// File: verification/tesc_trig_model.sv
// Trigger source model: user unit on the power pin, grabber on the link pin
`timescale 1ns/1ps
module tesc_trig_model (
  // Clock
  input wire logic ref_clk_i,
  // Trigger pins
  output logic power_conn_trigger_o,
  output logic link_trigger_o
);
  // ==========================================================================
  // State
  // ==========================================================================
  logic link_act = 1'b0; // Active level the grabber uses on the link pin
  logic pw_low = 1'b0;
  logic lk_on = 1'b0;

  // Unused side idles at its inactive level, else the OR would stick active
  assign power_conn_trigger_o = ~pw_low;
  assign link_trigger_o = lk_on ? link_act : ~link_act;

  // One trigger pulse; the caller uses widths from a two-cycle glitch up to forty lines
  task automatic pulse(input bit link, input int cyc);
    @(posedge ref_clk_i);
    if (link)
      lk_on <= 1'b1;
    else
      pw_low <= 1'b1;
    repeat (cyc) @(posedge ref_clk_i);
    lk_on <= 1'b0;
    pw_low <= 1'b0;
  endtask
endmodule
